// ### verilog/notch_multispeed_positioning.sv
// Command execution for notch-output and multi-speed positioning moves
`timescale 1ns/1ns
`default_nettype none
`include "notch_msp_regs.svh"
module notch_multispeed_positioning
	import notch_msp_pkg::*;
#(
	parameter int STAGES = 16
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	input wire pos_t AXIS_POS,
	input wire logic AXIS_STOPPED,
	output logic SERVO_ON,
	output speed_t SPEED_CMD,
	output pos_t TARGET_POS,
	output logic MOVE_REVERSE,
	output logic DECEL_STOP,
	output logic NOTCH1_OUT,
	output logic NOTCH2_OUT,
	output logic MOVE_BUSY,
	output logic CMD_ERROR
);
	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	move_state_e state_reg;
	move_kind_e kind_reg;
	logic [31:0] cmd_lo_reg;
	logic [31:0] cmd_hi_reg;
	logic error_reg;
	logic position_select_reg;
	logic [1:0] output_config_reg;
	pos_t notch_one_low_limit;
	pos_t notch_one_high_limit;
	pos_t notch_two_low_limit;
	pos_t notch_two_high_limit;
	logic [4:0] switch_point_count;
	speed_t initial_stage_speed;
	speed_t feed_speed_reg;
	pos_t start_pos_reg;
	pos_t target_reg;
	logic reverse_reg;
	logic [4:0] stage_idx_reg;
	speed_t next_stage_speed_reg;
	speed_t speed_reg;
	logic decel_reg;
	logic [31:0] rdata_reg;

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	logic wr_cmd_lo;
	logic start_rise;
	logic cancel_rise;
	logic [3:0] cmd_code;
	logic code_ok;
	logic accept;
	logic table_wr;
	logic clear_error;
	pos_t cmd_value;
	pos_t travelled;
	pos_t notch_pos;
	logic switch_hit;
	logic at_target;
	logic notch_run;
	logic notch_one_hit;
	logic notch_two_hit;
	logic limit_ok;
	offset_t stage_offset;
	speed_t stage_speed;
	offset_t rd_offset;
	speed_t rd_speed;
	logic [3:0] stage_sel;

	assign wr_cmd_lo = REG_WR && (REG_ADDR == `ADDR_CMD_LO);
	assign start_rise = wr_cmd_lo && REG_WDATA[`BIT_START] && !cmd_lo_reg[`BIT_START];
	assign cancel_rise = wr_cmd_lo && REG_WDATA[`BIT_CANCEL] && !cmd_lo_reg[`BIT_CANCEL];
	assign cmd_code = REG_WDATA[`CODE_MSB:`CODE_LSB];
	assign code_ok = (cmd_code == `CODE_NOTCH) || (cmd_code == `CODE_MULTI);
	assign accept = start_rise && (state_reg == ST_IDLE) && REG_WDATA[`BIT_SERVO] && code_ok;
	assign table_wr = REG_WR && ((REG_ADDR[7:6] == `ADDR_TABLE_OFFSET) || (REG_ADDR[7:6] == `ADDR_TABLE_SPEED));
	assign clear_error = REG_WR && (REG_ADDR == `ADDR_STATUS) && REG_WDATA[`BIT_ERROR];
	assign cmd_value = cmd_hi_reg;
	assign limit_ok = ($signed(REG_WDATA) >= `POS_MIN) && ($signed(REG_WDATA) <= `POS_MAX);
	assign travelled = reverse_reg ? (start_pos_reg - AXIS_POS) : (AXIS_POS - start_pos_reg);
	// Stage k waits for offset k; speed k is latched as the hit moves on to stage k+1
	assign stage_sel = stage_idx_reg[3:0];
	assign switch_hit = (state_reg == ST_MOVING) && (kind_reg == KIND_MULTI) &&
		(stage_idx_reg < switch_point_count) &&
		(travelled >= $signed({5'b0_0000, stage_offset}));
	assign at_target = (AXIS_POS == target_reg);
	assign notch_run = (state_reg == ST_MOVING) && (kind_reg == KIND_NOTCH);
	assign notch_pos = position_select_reg ? (AXIS_POS - start_pos_reg) : AXIS_POS;

	// ------------------------------------------------------------------
	// Command message and settings
	// ------------------------------------------------------------------
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cmd_lo_reg <= 32'h0000_0000;
			cmd_hi_reg <= 32'h0000_0000;
		end else if (REG_WR && (REG_ADDR == `ADDR_CMD_LO)) begin
			cmd_lo_reg <= REG_WDATA;
		end else if (REG_WR && (REG_ADDR == `ADDR_CMD_HI)) begin
			cmd_hi_reg <= REG_WDATA;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			position_select_reg <= 1'b0;
			output_config_reg <= 2'b00;
			notch_one_low_limit <= 32'sh0000_0000;
			notch_one_high_limit <= 32'sh0000_0000;
			notch_two_low_limit <= 32'sh0000_0000;
			notch_two_high_limit <= 32'sh0000_0000;
			switch_point_count <= 5'h00;
			initial_stage_speed <= `SPEED_DEFAULT;
			feed_speed_reg <= `SPEED_DEFAULT;
		end else if (REG_WR) begin
			unique case (REG_ADDR)
				`ADDR_NOTCH_CFG: begin
					if (REG_WDATA[31:3] == 29'h0000_0000) begin
						position_select_reg <= REG_WDATA[0];
						output_config_reg <= REG_WDATA[2:1];
					end
				end
				`ADDR_NOTCH1_LO: if (limit_ok) notch_one_low_limit <= REG_WDATA;
				`ADDR_NOTCH1_HI: if (limit_ok) notch_one_high_limit <= REG_WDATA;
				`ADDR_NOTCH2_LO: if (limit_ok) notch_two_low_limit <= REG_WDATA;
				`ADDR_NOTCH2_HI: if (limit_ok) notch_two_high_limit <= REG_WDATA;
				`ADDR_SWITCH_COUNT: begin
					if ((REG_WDATA[31:5] == 27'h000_0000) && (REG_WDATA[4:0] <= `COUNT_MAX)) begin
						switch_point_count <= REG_WDATA[4:0];
					end
				end
				`ADDR_INIT_SPEED: begin
					if ((REG_WDATA[31:18] == 14'h0000) && (REG_WDATA[17:0] != 18'h0_0000) &&
						(REG_WDATA[17:0] <= `SPEED_MAX)) begin
						initial_stage_speed <= REG_WDATA[17:0];
					end
				end
				`ADDR_FEED_SPEED: begin
					if ((REG_WDATA[31:18] == 14'h0000) && (REG_WDATA[17:0] != 18'h0_0000) &&
						(REG_WDATA[17:0] <= `SPEED_MAX)) begin
						feed_speed_reg <= REG_WDATA[17:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Move sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_reg <= ST_IDLE;
			kind_reg <= KIND_NOTCH;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (accept) begin
						state_reg <= ST_MOVING;
						kind_reg <= (cmd_code == `CODE_MULTI) ? KIND_MULTI : KIND_NOTCH;
					end
				end
				ST_MOVING: begin
					if (cancel_rise) begin
						state_reg <= ST_STOPPING;
					end else if (at_target) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_STOPPING: begin
					if (AXIS_STOPPED) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Target and start position are latched when the move is taken
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			start_pos_reg <= 32'sh0000_0000;
			target_reg <= 32'sh0000_0000;
			reverse_reg <= 1'b0;
		end else if (accept) begin
			start_pos_reg <= AXIS_POS;
			if (REG_WDATA[`BIT_INCR]) begin
				target_reg <= AXIS_POS + cmd_value;
				reverse_reg <= cmd_value < 32'sh0000_0000;
			end else begin
				target_reg <= cmd_value;
				reverse_reg <= cmd_value < AXIS_POS;
			end
		end else if (cancel_rise && (state_reg == ST_MOVING)) begin
			target_reg <= AXIS_POS;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			stage_idx_reg <= 5'h00;
			next_stage_speed_reg <= `SPEED_DEFAULT;
		end else if (accept) begin
			stage_idx_reg <= 5'h00;
		end else if (switch_hit) begin
			stage_idx_reg <= stage_idx_reg + 5'h01;
			next_stage_speed_reg <= stage_speed;
		end
	end

	// Speed command; in a stepped move stage zero uses the initial speed
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			speed_reg <= 18'h0_0000;
			decel_reg <= 1'b0;
		end else begin
			decel_reg <= (state_reg == ST_MOVING && cancel_rise) || (state_reg == ST_STOPPING && !AXIS_STOPPED);
			if (state_reg != ST_MOVING || cancel_rise || at_target) begin
				speed_reg <= 18'h0_0000;
			end else if (kind_reg == KIND_NOTCH) begin
				speed_reg <= feed_speed_reg;
			end else if (stage_idx_reg == 5'h00) begin
				speed_reg <= initial_stage_speed;
			end else begin
				speed_reg <= next_stage_speed_reg;
			end
		end
	end

	// Command error is sticky; a new event wins over a clear
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			error_reg <= 1'b0;
		end else if (start_rise && (state_reg != ST_IDLE)) begin
			error_reg <= 1'b1;
		end else if (clear_error) begin
			error_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Notch outputs and stage table
	// ------------------------------------------------------------------
	notch_window notch_one (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.enable(notch_run),
		.pos(notch_pos),
		.low_limit(notch_one_low_limit),
		.high_limit(notch_one_high_limit),
		.hit(notch_one_hit)
	);

	notch_window notch_two (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.enable(notch_run),
		.pos(notch_pos),
		.low_limit(notch_two_low_limit),
		.high_limit(notch_two_high_limit),
		.hit(notch_two_hit)
	);

	stage_table #(
		.DEPTH(STAGES)
	) table_inst (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.wr_en(table_wr),
		.wr_speed(REG_ADDR[7]),
		.wr_idx(REG_ADDR[5:2]),
		.wr_data(REG_WDATA),
		.stage_sel(stage_sel),
		.rd_idx(REG_ADDR[5:2]),
		.stage_offset(stage_offset),
		.stage_speed(stage_speed),
		.rd_offset(rd_offset),
		.rd_speed(rd_speed)
	);

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rdata_reg <= 32'h0000_0000;
		end else if (!REG_RD) begin
			rdata_reg <= 32'h0000_0000;
		end else if (REG_ADDR[7:6] == `ADDR_TABLE_OFFSET) begin
			rdata_reg <= {5'b0_0000, rd_offset};
		end else if (REG_ADDR[7:6] == `ADDR_TABLE_SPEED) begin
			rdata_reg <= {14'h0000, rd_speed};
		end else begin
			unique case (REG_ADDR)
				`ADDR_CMD_LO: rdata_reg <= cmd_lo_reg;
				`ADDR_CMD_HI: rdata_reg <= cmd_hi_reg;
				`ADDR_STATUS: rdata_reg <= {23'h00_0000, stage_idx_reg, error_reg, notch_two_hit,
					notch_one_hit, (state_reg != ST_IDLE)};
				`ADDR_NOTCH_CFG: rdata_reg <= {29'h0000_0000, output_config_reg, position_select_reg};
				`ADDR_NOTCH1_LO: rdata_reg <= notch_one_low_limit;
				`ADDR_NOTCH1_HI: rdata_reg <= notch_one_high_limit;
				`ADDR_NOTCH2_LO: rdata_reg <= notch_two_low_limit;
				`ADDR_NOTCH2_HI: rdata_reg <= notch_two_high_limit;
				`ADDR_SWITCH_COUNT: rdata_reg <= {27'h000_0000, switch_point_count};
				`ADDR_INIT_SPEED: rdata_reg <= {14'h0000, initial_stage_speed};
				`ADDR_FEED_SPEED: rdata_reg <= {14'h0000, feed_speed_reg};
				`ADDR_SPEED_NOW: rdata_reg <= {14'h0000, speed_reg};
				`ADDR_TARGET_NOW: rdata_reg <= target_reg;
				default: rdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	assign REG_RDATA = rdata_reg;
	assign SERVO_ON = cmd_lo_reg[`BIT_SERVO];
	assign SPEED_CMD = speed_reg;
	assign TARGET_POS = target_reg;
	assign MOVE_REVERSE = reverse_reg;
	assign DECEL_STOP = decel_reg;
	assign NOTCH1_OUT = notch_one_hit;
	assign NOTCH2_OUT = notch_two_hit;
	assign MOVE_BUSY = (state_reg != ST_IDLE);
	assign CMD_ERROR = error_reg;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	start_begins_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		accept |=> MOVE_BUSY && (kind_reg == ($past(cmd_code) == `CODE_MULTI ? KIND_MULTI : KIND_NOTCH)))
		else $error("accepted start did not begin the move");
	busy_error_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(start_rise && MOVE_BUSY) |=> CMD_ERROR && MOVE_BUSY)
		else $error("start during move did not flag error");
	incr_target_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(accept && REG_WDATA[`BIT_INCR]) |=> TARGET_POS == $past(AXIS_POS) + $past(cmd_hi_reg))
		else $error("incremental target wrong");
	cancel_stop_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(cancel_rise && state_reg == ST_MOVING) |=> (SPEED_CMD == 18'h0_0000) && DECEL_STOP
		##[0:300] !MOVE_BUSY)
		else $error("cancel did not stop the move");
	notch_gate_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!notch_run |=> !NOTCH1_OUT && !NOTCH2_OUT)
		else $error("notch output outside notch move");
	stage_step_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(switch_hit && !accept) |=> stage_idx_reg == $past(stage_idx_reg) + 5'h01)
		else $error("stage did not advance at switching point");
	stage_speed_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(state_reg == ST_MOVING && kind_reg == KIND_MULTI && stage_idx_reg == 5'h00 && !cancel_rise && !at_target)
		|=> SPEED_CMD == $past(initial_stage_speed))
		else $error("first stage speed wrong");
	count_range_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		switch_point_count <= `COUNT_MAX)
		else $error("switch point count out of range");
	init_speed_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(initial_stage_speed != 18'h0_0000) && (initial_stage_speed <= `SPEED_MAX))
		else $error("initial speed out of range");
	stage_bound_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(stage_idx_reg >= switch_point_count) |=> stage_idx_reg <= $past(stage_idx_reg) || $past(accept))
		else $error("stage index passed active count");
endmodule // notch_multispeed_positioning
`default_nettype wire

// ### common/notch_msp_regs.svh
// Register map, field positions, reset values and limits of the positioning block
`ifndef NOTCH_MSP_REGS_SVH
`define NOTCH_MSP_REGS_SVH

// --------------------------------------------------------------------------
// Register offsets (byte addresses) and table region codes (REG_ADDR[7:6])
// --------------------------------------------------------------------------
`define ADDR_CMD_LO 8'h00
`define ADDR_CMD_HI 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_NOTCH_CFG 8'h0C
`define ADDR_NOTCH1_LO 8'h10
`define ADDR_NOTCH1_HI 8'h14
`define ADDR_NOTCH2_LO 8'h18
`define ADDR_NOTCH2_HI 8'h1C
`define ADDR_SWITCH_COUNT 8'h20
`define ADDR_INIT_SPEED 8'h24
`define ADDR_FEED_SPEED 8'h28
`define ADDR_SPEED_NOW 8'h2C
`define ADDR_TARGET_NOW 8'h30
`define ADDR_TABLE_OFFSET 2'b01
`define ADDR_TABLE_SPEED 2'b10

// --------------------------------------------------------------------------
// Command message fields
// --------------------------------------------------------------------------
`define BIT_START 0
`define BIT_SERVO 1
`define BIT_CANCEL 2
`define CODE_LSB 8
`define CODE_MSB 11
`define BIT_INCR 24
`define CODE_NOP 4'h0
`define CODE_NOTCH 4'h3
`define CODE_MULTI 4'h4

// --------------------------------------------------------------------------
// Status fields
// --------------------------------------------------------------------------
`define BIT_BUSY 0
`define BIT_NOTCH1 1
`define BIT_NOTCH2 2
`define BIT_ERROR 3

// --------------------------------------------------------------------------
// Ranges and reset values
// --------------------------------------------------------------------------
`define POS_MAX 32'sh05F5_E0FF
`define POS_MIN 32'shFA0A_1F01
`define OFFSET_MAX 27'h5F5_E0FF
`define SPEED_MAX 18'h3_A980
`define SPEED_DEFAULT 18'h0_5DC0
`define COUNT_MAX 5'h10

`endif

// ### common/notch_msp_pkg.sv
// Types shared by the positioning block
package notch_msp_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MOVING = 2'b01,
		ST_STOPPING = 2'b10
	} move_state_e;
	typedef enum logic {
		KIND_NOTCH = 1'b0,
		KIND_MULTI = 1'b1
	} move_kind_e;
	typedef logic signed [31:0] pos_t;
	typedef logic [17:0] speed_t;
	typedef logic [26:0] offset_t;
endpackage

// ### verilog/notch_window.sv
// Position window comparator driving one notch output
`timescale 1ns/1ns
`default_nettype none
module notch_window
	import notch_msp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire pos_t pos,
	input wire pos_t low_limit,
	input wire pos_t high_limit,
	output logic hit
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hit <= 1'b0;
		end else begin
			hit <= enable && (pos >= low_limit) && (pos <= high_limit);
		end
	end

	window_follow_a: assert property (@(posedge clk) disable iff (rst)
		hit == $past(enable && (pos >= low_limit) && (pos <= high_limit)))
		else $error("notch output does not follow window");
endmodule // notch_window
`default_nettype wire

// ### verilog/stage_table.sv
// Speed switching offsets and speeds for the stepped move
`timescale 1ns/1ns
`default_nettype none
`include "notch_msp_regs.svh"
module stage_table
	import notch_msp_pkg::*;
#(
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic wr_speed,
	input wire logic [$clog2(DEPTH)-1:0] wr_idx,
	input wire logic [31:0] wr_data,
	input wire logic [$clog2(DEPTH)-1:0] stage_sel,
	input wire logic [$clog2(DEPTH)-1:0] rd_idx,
	output offset_t stage_offset,
	output speed_t stage_speed,
	output offset_t rd_offset,
	output speed_t rd_speed
);
	offset_t offset_mem [DEPTH];
	speed_t speed_mem [DEPTH];
	logic offset_ok;
	logic speed_ok;

	assign offset_ok = (wr_data[31:27] == 5'h00) && (wr_data[26:0] <= `OFFSET_MAX);
	assign speed_ok = (wr_data[31:18] == 14'h0000) && (wr_data[17:0] != 18'h0_0000) &&
		(wr_data[17:0] <= `SPEED_MAX);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				offset_mem[i] <= 27'h000_0000;
				speed_mem[i] <= `SPEED_DEFAULT;
			end
		end else if (wr_en) begin
			if (wr_speed && speed_ok) begin
				speed_mem[wr_idx] <= wr_data[17:0];
			end else if (!wr_speed && offset_ok) begin
				offset_mem[wr_idx] <= wr_data[26:0];
			end
		end
	end

	assign stage_offset = offset_mem[stage_sel];
	assign stage_speed = speed_mem[stage_sel];
	assign rd_offset = offset_mem[rd_idx];
	assign rd_speed = speed_mem[rd_idx];

	speed_range_a: assert property (@(posedge clk) disable iff (rst)
		(stage_speed != 18'h0_0000) && (stage_speed <= `SPEED_MAX))
		else $error("switching speed out of range");
	offset_range_a: assert property (@(posedge clk) disable iff (rst)
		stage_offset <= `OFFSET_MAX)
		else $error("switching offset out of range");
endmodule // stage_table
`default_nettype wire

// ### sim/axis_model.sv
// Behavioural servo axis that steps one unit per cycle toward the commanded target
`timescale 1ns/1ns
`default_nettype none
module axis_model
	import notch_msp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire speed_t speed,
	input wire pos_t target,
	input wire logic reverse,
	output pos_t pos,
	output logic stopped
);
	// --------------------------------------------------------------------------
	// Motion
	// --------------------------------------------------------------------------
	// Any nonzero speed moves one unit a cycle, so stage changes show up by position
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pos <= 32'sh0000_0000;
		end else if (speed != 18'h0_0000 && pos != target) begin
			pos <= reverse ? pos - 32'sh0000_0001 : pos + 32'sh0000_0001;
		end
	end
	assign stopped = (speed == 18'h0_0000);
endmodule // axis_model
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the notch and multi-speed positioning block
`timescale 1ns/1ns
`default_nettype none
`include "notch_msp_regs.svh"
module tb import notch_msp_pkg::*;;
	logic sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, h2;
	pos_t axis_pos, target_pos;
	speed_t speed_cmd;
	logic axis_stopped, servo_on, move_reverse, decel_stop, notch1_out, notch2_out, move_busy, cmd_error;
	int fails = 0, check_count = 0, n1 = 0, n2 = 0;
	logic [31:0] last = 32'h0000_0000, seen[$], seen_at[$], exp_spd[3];
	always #5 sys_clk = ~sys_clk;
	notch_multispeed_positioning #(.STAGES(16)) u_notch_multispeed_positioning (.SYS_CLK(sys_clk),
		.SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .AXIS_POS(axis_pos), .AXIS_STOPPED(axis_stopped), .SERVO_ON(servo_on),
		.SPEED_CMD(speed_cmd), .TARGET_POS(target_pos), .MOVE_REVERSE(move_reverse), .DECEL_STOP(decel_stop),
		.NOTCH1_OUT(notch1_out), .NOTCH2_OUT(notch2_out), .MOVE_BUSY(move_busy), .CMD_ERROR(cmd_error));
	axis_model u_axis_model (.clk(sys_clk), .rst(sys_rst), .speed(speed_cmd), .target(target_pos),
		.reverse(move_reverse), .pos(axis_pos), .stopped(axis_stopped));
	// --------------------------------------------------------------------------
	// Reference bookkeeping: notch high cycles and the order of commanded speeds
	// --------------------------------------------------------------------------
	always @(posedge sys_clk) begin
		n1 += int'(notch1_out === 1'b1);
		n2 += int'(notch2_out === 1'b1);
		if (move_busy === 1'b1 && speed_cmd != 18'h0_0000 && {14'h0000, speed_cmd} != last) begin
			last = {14'h0000, speed_cmd};
			seen.push_back(last);
			seen_at.push_back(axis_pos);
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// Command code cleared first, then the start bit is given a clean rise
	task go(input logic [31:0] lo);
		wr(`ADDR_CMD_LO, 32'h0000_0002);
		wr(`ADDR_CMD_LO, lo & 32'hFFFF_FFFE);
		wr(`ADDR_CMD_LO, lo | 32'h0000_0001);
	endtask
	task wait_idle;
		repeat (2) @(posedge sys_clk);
		for (int i = 0; i < 3000 && move_busy !== 1'b0; i++) @(posedge sys_clk);
		#1 chk({31'h0, move_busy}, 32'h0000_0000);
	endtask
	task end_of_test;
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#400000;
		fails++;
		end_of_test;
	end
	// --------------------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------------------
	initial begin
		void'($urandom(32'h450b));
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(`ADDR_NOTCH1_LO, 32'h0000_0000);
		rd(`ADDR_NOTCH2_HI, 32'h0000_0000);
		rd(`ADDR_NOTCH_CFG, 32'h0000_0000);
		rd(`ADDR_SWITCH_COUNT, 32'h0000_0000);
		rd(`ADDR_INIT_SPEED, 32'h0000_5DC0);
		rd(8'h40, 32'h0000_0000);
		rd(8'hBC, 32'h0000_5DC0);
		rd(8'h3C, 32'h0000_0000);
		wr(`ADDR_SWITCH_COUNT, 32'h0000_0011);
		rd(`ADDR_SWITCH_COUNT, 32'h0000_0000);
		wr(`ADDR_SWITCH_COUNT, 32'h0000_0010);
		rd(`ADDR_SWITCH_COUNT, 32'h0000_0010);
		wr(`ADDR_NOTCH_CFG, 32'h0000_0007);
		wr(`ADDR_NOTCH_CFG, 32'h0000_0008);
		rd(`ADDR_NOTCH_CFG, 32'h0000_0007);
		wr(`ADDR_INIT_SPEED, 32'h0000_0000);
		rd(`ADDR_INIT_SPEED, 32'h0000_5DC0);
		wr(8'h40, 32'h05F5_E100);
		rd(8'h40, 32'h0000_0000);
		// Notch move from zero to 12, windows 3..5 and 7..h2
		h2 = 32'h0000_0007 + $urandom_range(3, 0);
		wr(`ADDR_NOTCH_CFG, 32'h0000_0000);
		wr(`ADDR_NOTCH1_LO, 32'h0000_0003);
		wr(`ADDR_NOTCH1_HI, 32'h0000_0005);
		wr(`ADDR_NOTCH2_LO, 32'h0000_0007);
		wr(`ADDR_NOTCH2_HI, h2);
		wr(`ADDR_CMD_HI, 32'h0000_000C);
		n1 = 0;
		n2 = 0;
		go(32'h0000_0302);
		#1 chk({31'h0, move_busy}, 32'h0000_0001);
		chk({31'h0, servo_on}, 32'h0000_0001);
		wr(`ADDR_CMD_LO, 32'h0000_0302);
		wr(`ADDR_CMD_LO, 32'h0000_0303);
		@(posedge sys_clk);
		#1 chk({31'h0, cmd_error}, 32'h0000_0001);
		wait_idle;
		chk(axis_pos, 32'h0000_000C);
		chk(n1, 32'h0000_0003);
		chk(n2, h2 - 32'h0000_0006);
		wr(`ADDR_STATUS, 32'h0000_0008);
		@(posedge sys_clk);
		#1 chk({31'h0, cmd_error}, 32'h0000_0000);
		wr(`ADDR_CMD_HI, 32'h0000_0005);
		go(32'h0100_0302);
		wait_idle;
		chk(axis_pos, 32'h0000_0011);
		chk(target_pos, 32'h0000_0011);
		// Two points used out of three loaded, offsets from the start at 17
		wr(`ADDR_SWITCH_COUNT, 32'h0000_0002);
		wr(`ADDR_INIT_SPEED, 32'h0000_0032);
		wr(8'h40, 32'h0000_0004);
		wr(8'h44, 32'h0000_0008);
		wr(8'h80, 32'h0000_0064);
		wr(8'h84, 32'h0000_00C8);
		wr(8'h88, 32'h0000_012C);
		wr(`ADDR_CMD_HI, 32'h0000_0014);
		seen.delete();
		seen_at.delete();
		last = 32'h0000_0000;
		exp_spd = '{32'h0000_0032, 32'h0000_0064, 32'h0000_00C8};
		go(32'h0100_0402);
		wait_idle;
		chk(axis_pos, 32'h0000_0025);
		chk(seen.size(), 32'h0000_0003);
		foreach (exp_spd[i]) chk(seen[i], exp_spd[i]);
		// Each speed change must come at or after its switching point, start 17 plus offsets 4 and 8
		chk({31'h0, seen_at[1] >= 32'h0000_0015 && seen_at[1] < 32'h0000_0019}, 32'h0000_0001);
		chk({31'h0, seen_at[2] >= 32'h0000_0019 && seen_at[2] < 32'h0000_001D}, 32'h0000_0001);
		// Cancel a long move in mid-travel
		wr(`ADDR_CMD_HI, 32'h0000_03E8);
		go(32'h0000_0302);
		repeat (6) @(posedge sys_clk);
		wr(`ADDR_CMD_LO, 32'h0000_0307);
		#1 chk({31'h0, decel_stop}, 32'h0000_0001);
		chk({14'h0000, speed_cmd}, 32'h0000_0000);
		wait_idle;
		chk(32'(axis_pos < 32'sh0000_03E8), 32'h0000_0001);
		// Absolute move back toward a lower position
		wr(`ADDR_CMD_HI, 32'h0000_0020);
		go(32'h0000_0302);
		#1 chk({31'h0, move_reverse}, 32'h0000_0001);
		wait_idle;
		chk(axis_pos, 32'h0000_0020);
		go(32'h0000_0300);
		#1 chk({31'h0, move_busy}, 32'h0000_0000);
		go(32'h0000_0502);
		#1 chk({31'h0, move_busy}, 32'h0000_0000);
		end_of_test;
	end
endmodule // tb
`default_nettype wire
